// file: cell_link_pkg.sv
package cell_link_pkg;

   // Word and octet layout
   localparam int WORD_W = 32;
   localparam int OCTET_W = 8;
   localparam int LANES = 4;
   localparam int LANE_W = 2;
   localparam int PAIR_W = 2 * OCTET_W;
   localparam int FIRST_OCTET_LSB = 24;
   localparam int TX_FIFO_W = WORD_W + 1;
   localparam int TX_SOC_BIT = WORD_W;

   // Sizes
   localparam int TX_FIFO_DEPTH_DEF = 8;
   localparam int MIN_CELL_WORDS_DEF = 4;

   // Core clock figures
   localparam int MCLK_MHZ = 100;
   localparam int MCLK_PERIOD_NS = 10;
   localparam int CORE_CLK_MIN_MHZ = 60;
   localparam int CORE_CLK_MAX_MHZ = 146;

   // Link clock counted missing after this long without a half-rate toggle
   localparam int CLK_LOSS_NS = 200;
   localparam int LOSS_CYCLES_DEF = (CLK_LOSS_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

   localparam logic [LANE_W-1:0] LANE_FIRST = 2'h0;
   localparam logic [LANE_W-1:0] LANE_LAST = 2'h3;
   localparam logic [OCTET_W-1:0] IDLE_OCTET = 8'h00;
   localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [PAIR_W-1:0] PAIR_ZERO = 16'h0000;

   // Lane 0 is the first octet, in bits 31:24
   function automatic logic [OCTET_W-1:0] octet_sel(
      input logic [WORD_W-1:0] w,
      input logic [LANE_W-1:0] lane
   );
      logic [LANE_W-1:0] slot;
      slot = LANE_LAST - lane;
      octet_sel = w[slot * OCTET_W +: OCTET_W];
   endfunction

endpackage

// file: stream_if.sv
`timescale 1ns/1ns
interface stream_if #(
   parameter int WIDTH = 8
);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;

   modport src (
      output valid,
      output data,
      input ready
   );

   modport snk (
      input valid,
      input data,
      output ready
   );
endinterface

// file: cell_fifo.sv
`timescale 1ns/1ns
module cell_fifo
   import cell_link_pkg::*;
#(
   parameter int WIDTH = TX_FIFO_W,
   parameter int DEPTH = TX_FIFO_DEPTH_DEF
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clr_b,
   stream_if.snk wr,
   stream_if.src rd
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

   if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
      $error("cell_fifo needs DEPTH >= 2 and WIDTH >= 1");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;
   logic in_ready_q;
   logic out_valid_q;

   wire push = wr.valid & in_ready_q;
   wire pop = out_valid_q & rd.ready;
   wire [PTR_W-1:0] wr_ptr_d = (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
   wire [PTR_W-1:0] rd_ptr_d = (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;

   assign count_d = count_q + CNT_W'(push) - CNT_W'(pop);
   assign wr.ready = in_ready_q;
   assign rd.valid = out_valid_q;
   assign rd.data = mem_q[rd_ptr_q];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b || !clr_b) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
         in_ready_q <= 1'b0;
         out_valid_q <= 1'b0;
      end else begin
         if (push) wr_ptr_q <= wr_ptr_d;
         if (pop) rd_ptr_q <= rd_ptr_d;
         count_q <= count_d;
         in_ready_q <= count_d != FULL_CNT;
         out_valid_q <= count_d != '0;
      end
   end

   always_ff @(posedge clk) begin
      if (push) mem_q[wr_ptr_q] <= wr.data;
   end
endmodule

// file: link_ddr_capture.sv
`timescale 1ns/1ns
module link_ddr_capture
   import cell_link_pkg::*;
(
   input wire logic link_clk,
   input wire logic rst_b,
   input wire logic rx_rst_b,
   input wire logic [OCTET_W-1:0] octet_in,
   input wire logic soc_in,
   output logic [PAIR_W-1:0] pair_q,
   output logic soc_rise_q,
   output logic soc_fall_q
);
   logic [OCTET_W-1:0] rise_octet_q;
   logic rise_soc_q;
   logic [OCTET_W-1:0] fall_octet_q;
   logic fall_soc_q;

   // Rising-edge octet first, falling-edge octet second
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b || !rx_rst_b) begin
         rise_octet_q <= IDLE_OCTET;
         rise_soc_q <= 1'b0;
         pair_q <= PAIR_ZERO;
         soc_rise_q <= 1'b0;
         soc_fall_q <= 1'b0;
      end else begin
         rise_octet_q <= octet_in;
         rise_soc_q <= soc_in;
         pair_q <= {rise_octet_q, fall_octet_q};
         soc_rise_q <= rise_soc_q;
         soc_fall_q <= fall_soc_q;
      end
   end

   always_ff @(negedge link_clk or negedge rst_b) begin
      if (!rst_b || !rx_rst_b) begin
         fall_octet_q <= IDLE_OCTET;
         fall_soc_q <= 1'b0;
      end else begin
         fall_octet_q <= octet_in;
         fall_soc_q <= soc_in;
      end
   end
endmodule

// file: cell_link_channel.sv
`timescale 1ns/1ns
// Contract
// - Receive reset synchronous, clears receive storage
// - Transmit words captured into FIFO on clock
// - Transmit start flag marks first octet
// - Transmit reset synchronous, clears transmit storage
// - Output disable low tristates transmit drivers
// - Override ignored in reset, otherwise wins
// - Received octets delivered as 32-bit words
// - Receive start flag with first-octet word
// - Short previous cell flagged with start
// - Falling-edge start flagged one half cycle
// - Clock loss held while link clock absent
// - Receive half-rate clock from link clock
// - Core clock drives transmit FIFO and logic
module cell_link_channel
   import cell_link_pkg::*;
#(
   parameter int MIN_CELL_WORDS = MIN_CELL_WORDS_DEF,
   parameter int FIFO_DEPTH = TX_FIFO_DEPTH_DEF,
   parameter int LOSS_CYCLES = LOSS_CYCLES_DEF
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic tx_rst_b,
   input wire logic cell_enable,
   input wire logic [WORD_W-1:0] tx_word,
   input wire logic tx_cell_start,
   input wire logic tx_word_valid,
   output logic tx_word_ready,
   input wire logic tx_out_disable_b,
   input wire logic hiz_override_b,
   output logic [OCTET_W-1:0] link_transmit_data,
   output logic link_transmit_data_oe,
   output logic link_transmit_cell_start,
   output logic link_transmit_cell_start_oe,
   output logic link_transmit_clock,
   output logic link_transmit_clock_oe,
   input wire logic link_receive_clock,
   input wire logic rx_rst_b,
   input wire logic [OCTET_W-1:0] link_receive_data,
   input wire logic link_cell_start_in,
   output logic rx_half_clk,
   output logic [WORD_W-1:0] rx_word,
   output logic rx_word_valid,
   output logic rx_cell_start,
   output logic rx_min_cell_viol,
   output logic rx_align_err,
   output logic clock_loss
);
   localparam int LOSS_W = $clog2(LOSS_CYCLES + 1);
   localparam int CELL_W = $clog2(MIN_CELL_WORDS + 1);
   localparam logic [LOSS_W-1:0] LOSS_LIMIT = LOSS_W'(LOSS_CYCLES);
   localparam logic [CELL_W-1:0] MIN_CELL = CELL_W'(MIN_CELL_WORDS);

   if (MCLK_MHZ < CORE_CLK_MIN_MHZ || MCLK_MHZ > CORE_CLK_MAX_MHZ) begin : g_bad_clk
      $error("core clock outside its allowed range");
   end
   if (MIN_CELL_WORDS < 1 || LOSS_CYCLES < 2 || FIFO_DEPTH < 2) begin : g_bad_par
      $error("cell_link_channel parameters out of range");
   end

   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SEND = 2'b10
   } tx_state_e;

   // ------------------------------------------------------------------
   // Transmit path, core clock domain
   // ------------------------------------------------------------------
   stream_if #(.WIDTH(TX_FIFO_W)) tx_in_if ();
   stream_if #(.WIDTH(TX_FIFO_W)) tx_out_if ();

   assign tx_in_if.valid = tx_word_valid;
   assign tx_in_if.data = {tx_cell_start, tx_word};
   assign tx_word_ready = tx_in_if.ready;

   // FIFO runs on the core clock and is cleared by the transmit reset
   cell_fifo #(
      .WIDTH(TX_FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_tx_fifo (
      .clk(mclk),
      .rst_b(rst_b),
      .clr_b(tx_rst_b),
      .wr(tx_in_if.snk),
      .rd(tx_out_if.src)
   );

   tx_state_e tx_state_q;
   tx_state_e tx_state_d;
   logic [LANE_W-1:0] lane_q;
   logic [LANE_W-1:0] lane_d;
   logic [TX_FIFO_W-1:0] tx_hold_q;
   logic [OCTET_W-1:0] tx_octet_q;
   logic tx_soc_q;
   logic tx_clk_q;
   logic tx_oe_q;

   wire tx_sending = tx_state_q == TX_SEND;
   wire tx_last_lane = lane_q == LANE_LAST;
   // Next word is taken only while the fabric allows cells
   wire tx_load = tx_out_if.valid & cell_enable & (!tx_sending | tx_last_lane);
   wire [OCTET_W-1:0] tx_octet_d = tx_sending ? octet_sel(tx_hold_q[WORD_W-1:0], lane_q)
                                              : IDLE_OCTET;
   wire tx_soc_d = tx_sending & (lane_q == LANE_FIRST) & tx_hold_q[TX_SOC_BIT];

   assign tx_out_if.ready = tx_load;
   assign tx_state_d = tx_load ? TX_SEND : (tx_last_lane ? TX_IDLE : tx_state_q);
   assign lane_d = (tx_load || !tx_sending) ? LANE_FIRST : lane_q + 1'b1;

   // Override is ignored while the transmit reset is held
   wire tx_in_reset = !tx_rst_b;
   wire override_hiz = !hiz_override_b & !tx_in_reset;
   wire tx_oe_d = tx_out_disable_b & !override_hiz;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b || !tx_rst_b) begin
         tx_state_q <= TX_IDLE;
         lane_q <= LANE_FIRST;
      end else begin
         tx_state_q <= tx_state_d;
         lane_q <= lane_d;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b || !tx_rst_b) begin
         tx_hold_q <= '0;
      end else if (tx_load) begin
         tx_hold_q <= tx_out_if.data;
      end
   end

   // One octet per core cycle; link clock at half rate carries two per period
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b || !tx_rst_b) begin
         tx_octet_q <= IDLE_OCTET;
         tx_soc_q <= 1'b0;
         tx_clk_q <= 1'b0;
      end else begin
         tx_octet_q <= tx_octet_d;
         tx_soc_q <= tx_soc_d;
         tx_clk_q <= !tx_clk_q;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tx_oe_q <= 1'b0;
      end else begin
         tx_oe_q <= tx_oe_d;
      end
   end

   assign link_transmit_data = tx_octet_q;
   assign link_transmit_cell_start = tx_soc_q;
   assign link_transmit_clock = tx_clk_q;
   assign link_transmit_data_oe = tx_oe_q;
   assign link_transmit_cell_start_oe = tx_oe_q;
   assign link_transmit_clock_oe = tx_oe_q;

   // ------------------------------------------------------------------
   // Receive path, link clock domain
   // ------------------------------------------------------------------
   logic [PAIR_W-1:0] pair_q;
   logic pair_soc_rise_q;
   logic pair_soc_fall_q;

   link_ddr_capture u_rx_capture (
      .link_clk(link_receive_clock),
      .rst_b(rst_b),
      .rx_rst_b(rx_rst_b),
      .octet_in(link_receive_data),
      .soc_in(link_cell_start_in),
      .pair_q(pair_q),
      .soc_rise_q(pair_soc_rise_q),
      .soc_fall_q(pair_soc_fall_q)
   );

   logic en_meta_q;
   logic en_link_q;
   logic half_q;
   logic [PAIR_W-1:0] first_pair_q;
   logic first_rise_q;
   logic first_fall_q;
   logic [CELL_W-1:0] cell_words_q;
   logic [CELL_W-1:0] cell_words_d;
   logic cell_seen_q;
   logic [WORD_W-1:0] rx_word_q;
   logic rx_valid_q;
   logic rx_soc_q;
   logic rx_viol_q;
   logic rx_aln_q;

   // Word completes when the half-rate clock is high
   wire word_done = half_q & en_link_q;
   wire word_soc = first_rise_q | first_fall_q | pair_soc_rise_q | pair_soc_fall_q;
   wire word_aln = first_fall_q | pair_soc_fall_q;
   wire short_cell = cell_seen_q & (cell_words_q < MIN_CELL);
   wire [CELL_W-1:0] cell_words_inc = (cell_words_q == MIN_CELL) ? cell_words_q
                                                                 : cell_words_q + 1'b1;

   assign cell_words_d = word_soc ? CELL_W'(1) : cell_words_inc;

   // Enable crosses into the link domain
   always_ff @(posedge link_receive_clock or negedge rst_b) begin
      if (!rst_b || !rx_rst_b) begin
         en_meta_q <= 1'b0;
         en_link_q <= 1'b0;
      end else begin
         en_meta_q <= cell_enable;
         en_link_q <= en_meta_q;
      end
   end

   always_ff @(posedge link_receive_clock or negedge rst_b) begin
      if (!rst_b || !rx_rst_b) begin
         half_q <= 1'b0;
         first_pair_q <= PAIR_ZERO;
         first_rise_q <= 1'b0;
         first_fall_q <= 1'b0;
      end else begin
         half_q <= !half_q;
         if (!half_q) begin
            first_pair_q <= pair_q;
            first_rise_q <= pair_soc_rise_q;
            first_fall_q <= pair_soc_fall_q;
         end
      end
   end

   always_ff @(posedge link_receive_clock or negedge rst_b) begin
      if (!rst_b || !rx_rst_b) begin
         cell_words_q <= '0;
         cell_seen_q <= 1'b0;
      end else if (word_done) begin
         cell_words_q <= cell_words_d;
         cell_seen_q <= cell_seen_q | word_soc;
      end
   end

   // Outputs change as the half-rate clock falls and hold a full half-rate cycle
   always_ff @(posedge link_receive_clock or negedge rst_b) begin
      if (!rst_b || !rx_rst_b) begin
         rx_word_q <= WORD_ZERO;
         rx_valid_q <= 1'b0;
         rx_soc_q <= 1'b0;
         rx_viol_q <= 1'b0;
         rx_aln_q <= 1'b0;
      end else if (half_q) begin
         rx_word_q <= {first_pair_q, pair_q};
         rx_valid_q <= en_link_q;
         rx_soc_q <= en_link_q & word_soc;
         rx_viol_q <= en_link_q & word_soc & short_cell;
         rx_aln_q <= en_link_q & word_soc & word_aln;
      end
   end

   assign rx_half_clk = half_q;
   assign rx_word = rx_word_q;
   assign rx_word_valid = rx_valid_q;
   assign rx_cell_start = rx_soc_q;
   assign rx_min_cell_viol = rx_viol_q;
   assign rx_align_err = rx_aln_q;

   // ------------------------------------------------------------------
   // Link clock presence, core clock domain
   // ------------------------------------------------------------------
   logic alive_q;
   logic half_meta_q;
   logic half_sync_q;
   logic half_prev_q;
   logic [LOSS_W-1:0] loss_cnt_q;
   logic clock_loss_q;

   wire half_edge = half_sync_q ^ half_prev_q;

   // Free-running toggle, so a held receive reset is not taken for a lost clock
   always_ff @(posedge link_receive_clock or negedge rst_b) begin
      if (!rst_b) begin
         alive_q <= 1'b0;
      end else begin
         alive_q <= !alive_q;
      end
   end
   wire loss_reached = loss_cnt_q == LOSS_LIMIT;
   wire [LOSS_W-1:0] loss_cnt_d = half_edge ? '0 : (loss_reached ? loss_cnt_q
                                                                 : loss_cnt_q + 1'b1);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b || !tx_rst_b) begin
         half_meta_q <= 1'b0;
         half_sync_q <= 1'b0;
         half_prev_q <= 1'b0;
      end else begin
         half_meta_q <= alive_q;
         half_sync_q <= half_meta_q;
         half_prev_q <= half_sync_q;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b || !tx_rst_b) begin
         loss_cnt_q <= '0;
         clock_loss_q <= 1'b0;
      end else begin
         loss_cnt_q <= loss_cnt_d;
         clock_loss_q <= !half_edge & (loss_cnt_d == LOSS_LIMIT);
      end
   end

   assign clock_loss = clock_loss_q;
endmodule

// file: link_peer.sv
`timescale 1ns/1ns
module link_peer (
   input wire logic run,
   input wire logic half_clk,
   output logic lclk,
   output logic [7:0] data,
   output logic soc
);
   logic [33:0] q[$];
   logic [33:0] cur;
   logic ph;
   logic p0;
   task automatic push(input logic [33:0] w);
      q.push_back(w);
   endtask
   initial begin
      lclk = 1'b0;
      data = 8'h00;
      soc = 1'b0;
      ph = 1'b0;
      cur = '0;
      forever begin
         #12;
         // New word only on the receiver's word phase
         p0 = run && !ph && !half_clk && q.size() > 0;
         if (p0) cur = q.pop_front();
         data = p0 ? cur[31:24] : (ph ? cur[15:8] : 8'h00);
         soc = p0 && cur[33:32] == 2'h1;
         #12;
         // Clock stands still while stopped
         lclk = run;
         #12;
         data = p0 ? cur[23:16] : (ph ? cur[7:0] : ~data);
         soc = p0 && cur[33:32] == 2'h2;
         #12;
         lclk = 1'b0;
         ph = p0;
      end
   end
endmodule

// file: cell_link_channel_assertions.sv
`timescale 1ns/1ns
module cell_link_channel_assertions
   import cell_link_pkg::*;
#(
   parameter int LOSS_CYCLES = LOSS_CYCLES_DEF
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic tx_rst_b,
   input wire logic tx_out_disable_b,
   input wire logic hiz_override_b,
   input wire logic [OCTET_W-1:0] link_transmit_data,
   input wire logic link_transmit_data_oe,
   input wire logic link_transmit_cell_start,
   input wire logic link_transmit_cell_start_oe,
   input wire logic link_transmit_clock_oe,
   input wire logic link_receive_clock,
   input wire logic rx_rst_b,
   input wire logic rx_half_clk,
   input wire logic [WORD_W-1:0] rx_word,
   input wire logic rx_word_valid,
   input wire logic rx_cell_start,
   input wire logic rx_min_cell_viol,
   input wire logic rx_align_err,
   input wire logic clock_loss
);
   int unsigned gap_q;
   logic [1:0] half_q;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         gap_q <= 0;
         half_q <= 2'h0;
      end else begin
         half_q <= {half_q[0], rx_half_clk};
         gap_q <= (!tx_rst_b || !rx_rst_b || ^half_q) ? 0 : gap_q + 1;
      end
   end
   a_disable_tristates: assert property (
      @(posedge mclk) disable iff (!rst_b)
      !tx_out_disable_b |=> !link_transmit_data_oe && !link_transmit_clock_oe)
      else $error("disable did not tristate");
   a_override_wins: assert property (
      @(posedge mclk) disable iff (!rst_b)
      tx_rst_b && !hiz_override_b |=> !link_transmit_cell_start_oe)
      else $error("override did not tristate");
   a_override_ignored: assert property (
      @(posedge mclk) disable iff (!rst_b)
      !tx_rst_b && !hiz_override_b && tx_out_disable_b |=> link_transmit_data_oe)
      else $error("override acted in reset");
   a_tx_reset_clears: assert property (
      @(posedge mclk) disable iff (!rst_b)
      !tx_rst_b |=> link_transmit_data == 8'h00 && !link_transmit_cell_start)
      else $error("tx reset left output");
   a_tx_start_octets: assert property (
      @(posedge mclk) disable iff (!rst_b)
      link_transmit_cell_start |=> !link_transmit_cell_start [*3])
      else $error("start flag on later octet");
   a_loss_held: assert property (
      @(posedge mclk) disable iff (!rst_b)
      gap_q >= LOSS_CYCLES + 8 |-> clock_loss)
      else $error("clock loss not held");
   a_rx_reset_clears: assert property (
      @(posedge link_receive_clock) disable iff (!rst_b)
      !rx_rst_b ##1 !rx_rst_b |=> !rx_word_valid && !rx_cell_start && rx_word == '0)
      else $error("rx reset left output");
   a_viol_with_start: assert property (
      @(posedge link_receive_clock) disable iff (!rst_b)
      rx_min_cell_viol |-> rx_cell_start)
      else $error("violation without start");
   a_align_one_half: assert property (
      @(posedge link_receive_clock) disable iff (!rst_b)
      $rose(rx_align_err) |-> rx_cell_start ##1 rx_align_err ##1 !rx_align_err)
      else $error("alignment flag length wrong");
   a_half_rate_clock: assert property (
      @(posedge link_receive_clock) disable iff (!rst_b)
      $past(rx_rst_b) && $past(rx_rst_b, 2) |-> rx_half_clk != $past(rx_half_clk))
      else $error("half rate clock stuck");
   c_align: cover property (@(posedge link_receive_clock) rx_align_err);
   c_viol: cover property (@(posedge link_receive_clock) rx_min_cell_viol);
   c_loss: cover property (@(posedge mclk) clock_loss);
endmodule
bind cell_link_channel cell_link_channel_assertions #(.LOSS_CYCLES(LOSS_CYCLES)) chk_inst (.*);

// file: cell_link_channel_tb.sv
`timescale 1ns/1ns
module cell_link_channel_tb;
   import cell_link_pkg::*;
   localparam int LOSS = 8;
   localparam logic [WORD_W-1:0] IDLE_WORD = 32'h00FF_00FF;
   localparam logic [1:0] CODES [12] = '{2'h1, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0,
      2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1};
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic tx_rst_b = 1'b0;
   logic rx_rst_b = 1'b0;
   logic cell_enable = 1'b0;
   logic [WORD_W-1:0] tx_word = 32'h0000_0000;
   logic tx_cell_start = 1'b0;
   logic tx_word_valid = 1'b0;
   logic tx_out_disable_b = 1'b1;
   logic hiz_override_b = 1'b1;
   logic run = 1'b1;
   logic tx_word_ready, link_transmit_data_oe, link_transmit_cell_start;
   logic link_transmit_cell_start_oe, link_transmit_clock, link_transmit_clock_oe;
   logic link_receive_clock, link_cell_start_in, rx_half_clk, rx_word_valid;
   logic rx_cell_start, rx_min_cell_viol, rx_align_err, clock_loss;
   logic [OCTET_W-1:0] link_transmit_data, link_receive_data;
   logic [WORD_W-1:0] rx_word, seed = 32'h0000_0040, acc, w;
   logic s0, st, viol, tclk, sync = 1'b0;
   logic [32:0] tx_exp[$], e;
   logic [34:0] rx_exp[$], r;
   int miscompares = 0, checks_done = 0, cycles = 0, i, k = 0, n = 0;
   wire [2:0] oe_all = {link_transmit_data_oe, link_transmit_cell_start_oe,
      link_transmit_clock_oe};

   cell_link_channel #(.LOSS_CYCLES(LOSS)) cell_link_channel_inst (.*);
   link_peer link_peer_inst (.run(run), .half_clk(rx_half_clk),
      .lclk(link_receive_clock), .data(link_receive_data), .soc(link_cell_start_in));

   always #5 mclk = ~mclk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         test_done();
      end
   end

   // Rebuild link words from octets once the first start shows
   always @(negedge mclk) begin
      if (tx_exp.size() > 0 && (sync || link_transmit_cell_start === 1'b1)) begin
         if (k == 0) s0 = link_transmit_cell_start;
         sync = 1'b1;
         check(link_transmit_clock !== tclk, "tx clock");
         tclk = link_transmit_clock;
         acc = {acc[23:0], link_transmit_data};
         k = (k + 1) % 4;
         if (k == 0) begin
            e = tx_exp.pop_front();
            check({s0, acc} === e, "tx word");
         end
      end
   end

   always @(posedge rx_half_clk) begin
      if (rx_word_valid === 1'b1 &&
          (rx_cell_start === 1'b1 || (rx_word !== '0 && rx_word !== IDLE_WORD))) begin
         r = rx_exp.size() > 0 ? rx_exp.pop_front() : 'x;
         check({rx_min_cell_viol, rx_align_err, rx_cell_start, rx_word} === r, "rx");
      end
   end

   initial begin
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (2) @(posedge mclk);
      tx_rst_b <= 1'b1;
      rx_rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      // Fill with drain stalled, ninth word waits
      for (i = 0; i < 9; i++) begin
         seed = lfsr(seed);
         st = (i == 0) || (i == 5);
         tx_word <= seed;
         tx_cell_start <= st;
         tx_word_valid <= 1'b1;
         tx_exp.push_back({st, seed});
         @(posedge mclk);
      end
      repeat (2) @(negedge mclk);
      check(tx_word_ready === 1'b0, "fifo full");
      @(posedge mclk);
      cell_enable <= 1'b1;
      do @(negedge mclk); while (tx_word_ready !== 1'b1);
      @(posedge mclk);
      tx_word_valid <= 1'b0;
      repeat (60) @(posedge mclk);
      check(tx_exp.size() == 0, "tx drained");
      for (i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         w = seed | 32'h0000_0001;
         st = CODES[i] != 2'h0;
         viol = st && n > 0 && n < MIN_CELL_WORDS_DEF;
         n = st ? 1 : n + 1;
         link_peer_inst.push({CODES[i], w});
         rx_exp.push_back({viol, CODES[i] == 2'h2, st, w});
      end
      repeat (300) @(posedge mclk);
      check(rx_exp.size() == 0, "rx drained");
      run <= 1'b0;
      repeat (LOSS + 12) @(posedge mclk);
      check(clock_loss === 1'b1, "loss");
      repeat (40) @(posedge mclk);
      check(clock_loss === 1'b1, "loss held");
      run <= 1'b1;
      repeat (30) @(posedge mclk);
      check(clock_loss === 1'b0, "loss clear");
      rx_rst_b <= 1'b0;
      repeat (20) @(posedge mclk);
      check(rx_word_valid === 1'b0 && rx_word === '0, "rx reset");
      check(clock_loss === 1'b0, "loss in rx reset");
      rx_rst_b <= 1'b1;
      for (i = 0; i < 8; i++) begin
         {tx_out_disable_b, hiz_override_b, tx_rst_b} <= i[2:0];
         repeat (3) @(posedge mclk);
         st = i[2] & (i[1] | ~i[0]);
         check(oe_all === {3{st}}, "oe");
      end
      test_done();
   end
endmodule
